// ---- pmd_pkg.sv ----
// package: constants and carrier types for the peripheral disable block
package pmd_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] PMD_OFF_DIS0   = 4'h0;
    localparam logic [3:0] PMD_OFF_DIS1   = 4'h4;
    localparam logic [3:0] PMD_OFF_DIS2   = 4'h8;
    localparam logic [3:0] PMD_OFF_STAT   = 4'hC;
    localparam int         PMD_ADDR_W     = 4;
    localparam int         PMD_REG_W      = 8;
    localparam int         PMD_NUM_REGS   = 3;
    localparam int         PMD_NUM_PERIPH = 8;
    localparam logic [7:0] PMD_RST_VAL    = 8'h00;
    localparam logic [31:0] PMD_ZERO32    = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions of the first disable register
    // ------------------------------------------------------------
    localparam int PMD_BIT_TIMER1  = 0;
    localparam int PMD_BIT_TIMER2  = 1;
    localparam int PMD_BIT_TIMER3  = 2;
    localparam int PMD_BIT_TIMER4  = 3;
    localparam int PMD_BIT_TIMER5  = 4;
    localparam int PMD_BIT_TIMER6  = 5;
    localparam int PMD_BIT_SERIAL1 = 6;
    localparam int PMD_BIT_SERIAL2 = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        serial2_off;
        logic        serial1_off;
        logic        timer6_off;
        logic        timer5_off;
        logic        timer4_off;
        logic        timer3_off;
        logic        timer2_off;
        logic        timer1_off;
    } pmd_dis0_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } pmd_wb_req_t;

endpackage : pmd_pkg

// ---- pmd_ctrl.sv ----
// peripheral module disable: registers, clock gates, resets, csr guards
// Operation
// - disable bits live in three registers
// - set bit cuts every clock to peripheral
// - disabled peripheral registers ignore writes, read undefined
// - clearing bit reloads peripheral registers' defaults
// - one means disabled, unclocked, unpowered; no power switch here, only clock gate and reset hold
// - zero means enabled; register resets to zero
// - bits 7..0: serial2, serial1, timer6..timer1
// - disabled peripheral is held in reset
`timescale 1ns/100ps
module pmd_ctrl
    import pmd_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone slave
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [PMD_ADDR_W-1:0]     adr_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    output logic                           err_o,
    // per-peripheral clock, reset and csr control
    output logic      [PMD_NUM_PERIPH-1:0] periph_clk_o,
    output logic      [PMD_NUM_PERIPH-1:0] periph_rst_o,
    output logic      [PMD_NUM_PERIPH-1:0] csr_wr_allow_o,
    output logic      [PMD_NUM_PERIPH-1:0] csr_rd_valid_o,
    output logic      [PMD_NUM_PERIPH-1:0] csr_reload_o,
    output pmd_dis0_t                      dis0_o
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic [2:0] pmd_dec(input logic [PMD_ADDR_W-1:0] a);
        logic [2:0] h;
        h = 3'h0;
        if (a == PMD_OFF_DIS0) h = 3'h1;
        else if (a == PMD_OFF_DIS1) h = 3'h2;
        else if (a == PMD_OFF_DIS2) h = 3'h4;
        return h;
    endfunction : pmd_dec

    pmd_wb_req_t req;
    logic [2:0]  hit;
    logic        hit_stat;
    logic        mapped;
    logic        take;
    logic        wr_lane0;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdat_d;
    logic [31:0] dat_q;

    assign req      = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                        adr: adr_i, dat: dat_i};
    assign hit      = pmd_dec(req.adr);
    assign hit_stat = (req.adr == PMD_OFF_STAT);
    assign mapped   = (|hit) | hit_stat;
    assign take     = req.cyc & req.stb & ~ack_q & ~err_q;
    assign wr_lane0 = take & req.we & req.sel[0];

    // ------------------------------------------------------------
    // disable registers, one byte each
    // ------------------------------------------------------------
    logic [PMD_REG_W-1:0] dis_q [PMD_NUM_REGS];
    logic [PMD_NUM_PERIPH-1:0] prev_q;

    genvar g;
    generate
        for (g = 0; g < PMD_NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    dis_q[g] <= PMD_RST_VAL;
                end else if (wr_lane0 && hit[g]) begin
                    dis_q[g] <= req.dat[PMD_REG_W-1:0];
                end
            end
        end
    endgenerate

    // only the first register has peripherals attached
    logic [PMD_NUM_PERIPH-1:0] off;
    assign off    = dis_q[0];
    assign dis0_o = pmd_dis0_t'(dis_q[0]);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdat_d = PMD_ZERO32;
        if (hit[0]) rdat_d[PMD_REG_W-1:0] = dis_q[0];
        else if (hit[1]) rdat_d[PMD_REG_W-1:0] = dis_q[1];
        else if (hit[2]) rdat_d[PMD_REG_W-1:0] = dis_q[2];
        else if (hit_stat) rdat_d[PMD_NUM_PERIPH-1:0] = csr_rd_valid_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            dat_q  <= PMD_ZERO32;
            prev_q <= '0;
        end else begin
            ack_q  <= take & mapped;
            err_q  <= take & ~mapped;
            dat_q  <= (take & ~req.we) ? rdat_d : PMD_ZERO32;
            prev_q <= off;
        end
    end

    assign ack_o = ack_q;
    assign err_o = err_q;
    assign dat_o = dat_q;

    // ------------------------------------------------------------
    // clock gating, reset hold and csr guards
    // ------------------------------------------------------------
    generate
        for (g = 0; g < PMD_NUM_PERIPH; g++) begin : g_gate
            logic en_lat;
            // latch is transparent while clock low, so enable
            // changes never clip a high phase
            always_latch begin
                if (!clk_i) en_lat <= ~off[g];
            end
            assign periph_clk_o[g]   = clk_i & en_lat;
            assign periph_rst_o[g]   = off[g] | rst_i;
            assign csr_wr_allow_o[g] = ~off[g];
            assign csr_rd_valid_o[g] = ~off[g];
            // one pulse on the falling edge of the bit
            assign csr_reload_o[g]   = prev_q[g] & ~off[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_write_sets_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lane0 && hit[0] |=> dis_q[0] == $past(req.dat[PMD_REG_W-1:0]))
        else $error("disable register write lost");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held too long");
    a_off_holds_rst: assert property (@(posedge clk_i) disable iff (rst_i)
        off[0] |-> periph_rst_o[0] && !csr_wr_allow_o[0])
        else $error("disabled timer not in reset");
    // the enable seen at an edge is the one latched in the low phase
    // before it, so a set bit must already have closed the gate
    a_off_cuts_clk: assert property (@(posedge clk_i) disable iff (rst_i)
        off[7] |-> !g_gate[7].en_lat)
        else $error("serial2 clock still enabled");
    // a reset also clears the bits but needs no reload pulse
    a_reload_on_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(off[1]) && !$past(rst_i) |->
            csr_reload_o[1] ##1 !csr_reload_o[1])
        else $error("reload pulse missing");
    a_no_spur_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        csr_reload_o[5] |-> $past(off[5]) && !off[5])
        else $error("spurious reload");
    a_field_map: assert property (@(posedge clk_i) disable iff (rst_i)
        dis0_o.serial2_off == dis_q[0][7] && dis0_o.timer1_off == dis_q[0][0])
        else $error("field map wrong");
    a_reset_zero: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i) |-> off == '0 && csr_wr_allow_o == 8'hFF)
        else $error("not enabled after reset");
    a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !mapped |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    c_disable: cover property (@(posedge clk_i) $rose(off[0]));
    c_reenable: cover property (@(posedge clk_i) csr_reload_o[6]);
    c_read_stat: cover property (@(posedge clk_i) take && hit_stat && !req.we);
    c_serial_off: cover property (@(posedge clk_i) $rose(off[7]));
    c_unmapped: cover property (@(posedge clk_i) err_o);

    // ------------------------------------------------------------
    // bus answer checks
    // ------------------------------------------------------------
    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        take && mapped |=> ack_o && !err_o)
        else $error("mapped access not acknowledged");
    a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("error held too long");
    // data bus stays quiet outside an answer, so stale bytes never leak
    a_idle_data_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == PMD_ZERO32)
        else $error("read data not cleared");

    // ------------------------------------------------------------
    // per-peripheral checks
    // ------------------------------------------------------------
    generate
        for (g = 0; g < PMD_NUM_PERIPH; g++) begin : g_chk
            a_gate_closed: assert property (@(posedge clk_i)
                disable iff (rst_i)
                off[g] |-> !g_gate[g].en_lat)
                else $error("gated clock still enabled");
            a_gate_open: assert property (@(posedge clk_i)
                disable iff (rst_i)
                !off[g] |-> g_gate[g].en_lat)
                else $error("gated clock not enabled");
            a_guard_levels: assert property (@(posedge clk_i)
                disable iff (rst_i)
                csr_wr_allow_o[g] == !off[g] &&
                csr_rd_valid_o[g] == !off[g])
                else $error("csr guard level wrong");
            a_rst_follows: assert property (@(posedge clk_i)
                disable iff (rst_i)
                periph_rst_o[g] == off[g])
                else $error("peripheral reset level wrong");
            // a longer pulse would reload twice and hide user writes
            a_reload_short: assert property (@(posedge clk_i)
                disable iff (rst_i)
                csr_reload_o[g] |=> !csr_reload_o[g])
                else $error("reload pulse too long");
        end
    endgenerate

endmodule : pmd_ctrl

// ---- pmd_ctrl_bench.sv ----
// testbench: disable register, clock gates and csr guard outputs
`timescale 1ns/100ps
module pmd_ctrl_bench
    import pmd_pkg::*;
;
    logic                      clk_i = 1'b0;
    logic                      rst_i = 1'b1;
    logic                      cyc_i = 1'b0;
    logic                      stb_i = 1'b0;
    logic                      we_i  = 1'b0;
    logic [3:0]                sel_i = 4'h0;
    logic [PMD_ADDR_W-1:0]     adr_i = 4'h0;
    logic [31:0]               dat_i = 32'h0;
    logic [31:0]               dat_o;
    logic                      ack_o, err_o;
    logic [PMD_NUM_PERIPH-1:0] clk_o, rst_o, allow_o, valid_o, reload_o;
    pmd_dis0_t                 dis0_o;
    logic [7:0]                rl_seen;
    int                        error_cnt = 0;
    int                        num_checks = 0;
    int                        cycles = 0;

    always #20 clk_i = ~clk_i;

    pmd_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .periph_clk_o(clk_o), .periph_rst_o(rst_o),
        .csr_wr_allow_o(allow_o), .csr_rd_valid_o(valid_o),
        .csr_reload_o(reload_o), .dis0_o(dis0_o));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // classic cycle; no fixed latency assumed, the global timeout guards
    task automatic wb(input logic w, input logic [3:0] a, s,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        q       = dat_o;
        e       = err_o;
        rl_seen = reload_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        for (int r = 0; r < 4; r++) begin
            wb(1'b0, 4'(r * 4), 4'hF, 32'h0, q, e);
            chk("reset value", q, (r == 3) ? 32'hFF : 32'h0);
        end
        chk("reset levels", {rst_o, allow_o}, 32'h00FF);
        $display("test reset done");
    endtask : t_reset

    task automatic t_bits;
        logic [31:0] q;
        logic        e;
        logic [7:0]  m, mn;
        for (int i = 0; i < 8; i++) begin
            m  = 8'h01 << i;
            mn = ~m;
            wb(1'b1, PMD_OFF_DIS0, 4'h1, {24'hFFFFFF, m}, q, e);
            chk("dis0", {24'h0, dis0_o}, {24'h0, m});
            chk("held reset", {24'h0, rst_o}, {24'h0, m});
            chk("wr allow", {24'h0, allow_o}, {24'h0, mn});
            chk("rd valid", {24'h0, valid_o}, {24'h0, mn});
            // sample mid high phase where a running gate must be high
            @(posedge clk_i);
            #10;
            chk("gated clk", {24'h0, clk_o}, {24'h0, mn});
            @(posedge clk_i);
            wb(1'b0, PMD_OFF_DIS0, 4'hF, 32'h0, q, e);
            chk("readback", q, {24'h0, m});
            wb(1'b0, PMD_OFF_STAT, 4'hF, 32'h0, q, e);
            chk("status", q, {24'h0, mn});
            wb(1'b1, PMD_OFF_DIS0, 4'h1, 32'h0, q, e);
            chk("reload", {24'h0, rl_seen}, {24'h0, m});
            chk("released", {24'h0, rst_o}, 32'h0);
        end
        $display("test bits done");
    endtask : t_bits

    task automatic t_misc;
        logic [31:0] q;
        logic        e;
        wb(1'b1, PMD_OFF_DIS1, 4'h1, 32'hFFFF_FFA5, q, e);
        wb(1'b1, PMD_OFF_DIS2, 4'h1, 32'h0000_005A, q, e);
        wb(1'b0, PMD_OFF_DIS1, 4'hF, 32'h0, q, e);
        chk("dis1", q, 32'hA5);
        wb(1'b0, PMD_OFF_DIS2, 4'hF, 32'h0, q, e);
        chk("dis2", q, 32'h5A);
        wb(1'b1, PMD_OFF_DIS0, 4'hE, 32'hFF, q, e);
        chk("no sel", {23'h0, e, dis0_o}, 32'h0);
        wb(1'b1, 4'h2, 4'h1, 32'hFF, q, e);
        chk("unmapped", {23'h0, e, dis0_o}, 32'h100);
        wb(1'b1, PMD_OFF_STAT, 4'h1, 32'h0, q, e);
        wb(1'b0, PMD_OFF_STAT, 4'hF, 32'h0, q, e);
        chk("status ro", q, 32'hFF);
        wb(1'b1, PMD_OFF_DIS0, 4'h1, 32'hFF, q, e);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("re-reset", {16'h0, dis0_o, rst_o}, 32'h0);
        $display("test misc done");
    endtask : t_misc

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bits();
        t_misc();
        summarize();
    end
endmodule : pmd_ctrl_bench
